// ### inc/afr_map.vh
`ifndef AFR_MAP_VH
`define AFR_MAP_VH

// register byte offsets
`define AFR_OFS_REMAP        6'h00
`define AFR_OFS_FILT_AB      6'h18
`define AFR_OFS_FILT_CD      6'h1c
`define AFR_OFS_FILT_SET     6'h20
`define AFR_OFS_DIG_AB       6'h24
`define AFR_OFS_DIG_CD       6'h28

// remap control fields
`define AFR_SPI_A_IDLE_BIT   11
`define AFR_SPI_B_IDLE_BIT   10
`define AFR_INJ_ROUTE_BIT    9
`define AFR_REG_ROUTE_BIT    8
`define AFR_INJ_SEL_HI       7
`define AFR_INJ_SEL_LO       4
`define AFR_REG_SEL_HI       3
`define AFR_REG_SEL_LO       0
`define AFR_REMAP_MASK       32'h00000fff

// writable masks of the mixed registers
`define AFR_CD_MASK          32'hf001e000
`define AFR_FILT_SET_MASK    32'h0000001f

// reset value of every register
`define AFR_RESET_VALUE      32'h00000000

`endif

// ### rtl/afr_trig_mux.v
`timescale 1ns/1ps
// trigger source selection for the converter, registered
module afr_trig_mux (
    // clock and reset
    input  wire        clk,
    input  wire        rst,
    // configuration
    input  wire        route_timer,
    input  wire [3:0]  line_select,
    // sources, already synchronised
    input  wire [15:0] ext_lines,
    input  wire        timer_src,
    // result
    output reg         trig_q
);
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            trig_q <= 1'b0;
        end else if (route_timer) begin
            trig_q <= timer_src;
        end else begin
            trig_q <= ext_lines[line_select];
        end
    end
endmodule

// ### rtl/afr_config.v
// Function
// - bit 11 sets idle state of spi a select: 0 high-z, 1 drive high.
// - bit 10 sets idle state of spi b select: 0 high-z, 1 drive high.
// - bit 9 picks injected trigger: interrupt line or timer eight channel 4.
// - bit 8 picks regular trigger: interrupt line or timer eight trigger output.
// - bits 7:4 choose interrupt line for injected trigger.
// - bits 3:0 choose interrupt line for regular trigger.
//
// The Wishbone slave port was decided locally.
`timescale 1ns/1ps
`include "afr_map.vh"
module afr_config (
    // clock and reset
    input  wire        clk,
    input  wire        rst,
    // wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [5:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    output reg         wb_err_o,
    // select line idle behaviour from the spi controllers
    input  wire        spi_a_select_active,
    input  wire        spi_a_select_level,
    input  wire        spi_b_select_active,
    input  wire        spi_b_select_level,
    output reg         spi_a_select_o,
    output reg         spi_a_select_oe,
    output reg         spi_b_select_o,
    output reg         spi_b_select_oe,
    // trigger sources, asynchronous
    input  wire [15:0] external_interrupt_lines,
    input  wire        timer_eight_ch4_output,
    input  wire        timer_eight_trigger_output,
    // triggers to the converter
    output wire        conv_injected_trigger,
    output wire        conv_regular_trigger,
    // filter settings to the pads
    output reg  [31:0] pin_filter_ab,
    output reg  [31:0] pin_filter_cd,
    output reg  [4:0]  io_filter_config_field,
    output reg  [31:0] digital_filter_ab,
    output reg  [31:0] digital_filter_cd
);
    reg  [11:0] remap_q;
    reg  [17:0] src_s1_q;
    reg  [17:0] src_s2_q;
    wire [31:0] byte_mask;
    wire        req;
    wire        hit;
    reg  [31:0] rd_d;
    wire        wr_en;
    wire        rd_en;
    wire        wr_remap;
    wire        wr_filt_ab;
    wire        wr_filt_cd;
    wire        wr_filt_set;
    wire        wr_dig_ab;
    wire        wr_dig_cd;
    wire [31:0] remap_wide;

    assign byte_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    // ack only in the cycle after the request, dropped the cycle after
    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;

    function [31:0] merge;
        input [31:0] old;
        input [31:0] wdat;
        input [31:0] bmask;
        input [31:0] wmask;
        begin
            merge = ((old & ~(bmask & wmask)) | (wdat & bmask & wmask)) & wmask;
        end
    endfunction

    // one decode shared by the error reply and the write strobes
    function is_at;
        input [5:0] adr;
        input [5:0] ofs;
        begin
            is_at = (adr == ofs);
        end
    endfunction

    assign hit = is_at(wb_adr_i, `AFR_OFS_REMAP) | is_at(wb_adr_i, `AFR_OFS_FILT_AB) |
                 is_at(wb_adr_i, `AFR_OFS_FILT_CD) | is_at(wb_adr_i, `AFR_OFS_FILT_SET) |
                 is_at(wb_adr_i, `AFR_OFS_DIG_AB) | is_at(wb_adr_i, `AFR_OFS_DIG_CD);

    // a write lands on the taking edge, the same edge that raises ack
    assign wr_en       = req & hit & wb_we_i;
    assign rd_en       = req & hit & ~wb_we_i;
    assign wr_remap    = wr_en & is_at(wb_adr_i, `AFR_OFS_REMAP);
    assign wr_filt_ab  = wr_en & is_at(wb_adr_i, `AFR_OFS_FILT_AB);
    assign wr_filt_cd  = wr_en & is_at(wb_adr_i, `AFR_OFS_FILT_CD);
    assign wr_filt_set = wr_en & is_at(wb_adr_i, `AFR_OFS_FILT_SET);
    assign wr_dig_ab   = wr_en & is_at(wb_adr_i, `AFR_OFS_DIG_AB);
    assign wr_dig_cd   = wr_en & is_at(wb_adr_i, `AFR_OFS_DIG_CD);
    // reserved upper bits are dropped here; only twelve bits are stored
    assign remap_wide  = merge({20'h00000, remap_q}, wb_dat_i, byte_mask, `AFR_REMAP_MASK);

    always @* begin
        rd_d = `AFR_RESET_VALUE;
        case (wb_adr_i)
            `AFR_OFS_REMAP:    rd_d = {20'h00000, remap_q};
            `AFR_OFS_FILT_AB:  rd_d = pin_filter_ab;
            `AFR_OFS_FILT_CD:  rd_d = pin_filter_cd;
            `AFR_OFS_FILT_SET: rd_d = {27'h0000000, io_filter_config_field};
            `AFR_OFS_DIG_AB:   rd_d = digital_filter_ab;
            `AFR_OFS_DIG_CD:   rd_d = digital_filter_cd;
            default:           rd_d = `AFR_RESET_VALUE;
        endcase
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            wb_ack_o               <= 1'b0;
            wb_err_o               <= 1'b0;
            wb_dat_o               <= `AFR_RESET_VALUE;
        end else begin
            // err answers an unmapped offset, and nothing is written then
            wb_ack_o <= req & hit;
            wb_err_o <= req & ~hit;
            // zero outside the ack cycle, so no stale data lingers on the bus
            wb_dat_o <= rd_en ? rd_d : `AFR_RESET_VALUE;
        end
    end

    // remap control: mode bits, routes and line selects
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            remap_q <= 12'h000;
        end else if (wr_remap) begin
            remap_q <= remap_wide[11:0];
        end
    end

    // pin filter enables, every lane writable
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_filter_ab <= `AFR_RESET_VALUE;
        end else if (wr_filt_ab) begin
            pin_filter_ab <= merge(pin_filter_ab, wb_dat_i, byte_mask, 32'hffffffff);
        end
    end

    // reserved bits never store, so they always read back zero
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_filter_cd <= `AFR_RESET_VALUE;
        end else if (wr_filt_cd) begin
            pin_filter_cd <= merge(pin_filter_cd, wb_dat_i, byte_mask, `AFR_CD_MASK);
        end
    end

    // filter setting: only the low byte lane carries the five-bit field
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            io_filter_config_field <= 5'h00;
        end else if (wr_filt_set & wb_sel_i[0]) begin
            io_filter_config_field <= wb_dat_i[4:0];
        end
    end

    // digital filter enables, every lane writable
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            digital_filter_ab <= `AFR_RESET_VALUE;
        end else if (wr_dig_ab) begin
            digital_filter_ab <= merge(digital_filter_ab, wb_dat_i, byte_mask, 32'hffffffff);
        end
    end

    // same lane layout as the pin filter pair above
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            digital_filter_cd <= `AFR_RESET_VALUE;
        end else if (wr_dig_cd) begin
            digital_filter_cd <= merge(digital_filter_cd, wb_dat_i, byte_mask, `AFR_CD_MASK);
        end
    end

    // idle select pins: driven high or released, per mode bit
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            spi_a_select_o  <= 1'b0;
            spi_a_select_oe <= 1'b0;
            spi_b_select_o  <= 1'b0;
            spi_b_select_oe <= 1'b0;
        end else begin
            spi_a_select_o  <= spi_a_select_active ? spi_a_select_level : 1'b1;
            spi_a_select_oe <= spi_a_select_active | remap_q[`AFR_SPI_A_IDLE_BIT];
            spi_b_select_o  <= spi_b_select_active ? spi_b_select_level : 1'b1;
            spi_b_select_oe <= spi_b_select_active | remap_q[`AFR_SPI_B_IDLE_BIT];
        end
    end

    // two-stage synchroniser for the asynchronous trigger sources
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            src_s1_q <= 18'h00000;
            src_s2_q <= 18'h00000;
        end else begin
            src_s1_q <= {timer_eight_trigger_output, timer_eight_ch4_output,
                         external_interrupt_lines};
            src_s2_q <= src_s1_q;
        end
    end

    afr_trig_mux u_inj (
        .clk         (clk),
        .rst         (rst),
        .route_timer (remap_q[`AFR_INJ_ROUTE_BIT]),
        .line_select (remap_q[`AFR_INJ_SEL_HI:`AFR_INJ_SEL_LO]),
        .ext_lines   (src_s2_q[15:0]),
        .timer_src   (src_s2_q[16]),
        .trig_q      (conv_injected_trigger)
    );

    afr_trig_mux u_reg (
        .clk         (clk),
        .rst         (rst),
        .route_timer (remap_q[`AFR_REG_ROUTE_BIT]),
        .line_select (remap_q[`AFR_REG_SEL_HI:`AFR_REG_SEL_LO]),
        .ext_lines   (src_s2_q[15:0]),
        .timer_src   (src_s2_q[17]),
        .trig_q      (conv_regular_trigger)
    );
endmodule

// ### tb/afr_config_asserts.sv
`timescale 1ns/1ps
module afr_config_asserts (
    // clock and reset
    input wire        clk,
    input wire        rst,
    // bus handshake
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire        wb_ack_o,
    input wire        wb_err_o,
    // select pins
    input wire        spi_a_select_active,
    input wire        spi_a_select_o,
    input wire        spi_a_select_oe,
    input wire        spi_b_select_active,
    input wire        spi_b_select_o,
    input wire        spi_b_select_oe,
    // trigger sources and results
    input wire [15:0] external_interrupt_lines,
    input wire        timer_eight_ch4_output,
    input wire        timer_eight_trigger_output,
    input wire        conv_injected_trigger,
    input wire        conv_regular_trigger
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    property p_answer;
        wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=> (wb_ack_o ^ wb_err_o) ##1 !wb_ack_o;
    endproperty
    a_answer: assert property (p_answer) else $error("bad answer");
    property p_spi_a_idle;
        !$past(spi_a_select_active) && spi_a_select_oe |-> spi_a_select_o;
    endproperty
    a_spi_a_idle: assert property (p_spi_a_idle) else $error("spi a idle low");
    property p_spi_b_idle;
        !$past(spi_b_select_active) && spi_b_select_oe |-> spi_b_select_o;
    endproperty
    a_spi_b_idle: assert property (p_spi_b_idle) else $error("spi b idle low");
    // three edges of latency, so four quiet samples fix the output
    property p_inj_low;
        (external_interrupt_lines == 0 && !timer_eight_ch4_output) [*4] |-> !conv_injected_trigger;
    endproperty
    a_inj_low: assert property (p_inj_low) else $error("inj high");
    property p_inj_high;
        (&external_interrupt_lines && timer_eight_ch4_output) [*4] |-> conv_injected_trigger;
    endproperty
    a_inj_high: assert property (p_inj_high) else $error("inj low");
    property p_reg_low;
        (external_interrupt_lines == 0 && !timer_eight_trigger_output) [*4]
            |-> !conv_regular_trigger;
    endproperty
    a_reg_low: assert property (p_reg_low) else $error("reg high");
    property p_reg_high;
        (&external_interrupt_lines && timer_eight_trigger_output) [*4] |-> conv_regular_trigger;
    endproperty
    a_reg_high: assert property (p_reg_high) else $error("reg low");
endmodule
bind afr_config afr_config_asserts chk_u (
    .clk                        (clk),
    .rst                        (rst),
    .wb_cyc_i                   (wb_cyc_i),
    .wb_stb_i                   (wb_stb_i),
    .wb_ack_o                   (wb_ack_o),
    .wb_err_o                   (wb_err_o),
    .spi_a_select_active        (spi_a_select_active),
    .spi_a_select_o             (spi_a_select_o),
    .spi_a_select_oe            (spi_a_select_oe),
    .spi_b_select_active        (spi_b_select_active),
    .spi_b_select_o             (spi_b_select_o),
    .spi_b_select_oe            (spi_b_select_oe),
    .external_interrupt_lines   (external_interrupt_lines),
    .timer_eight_ch4_output     (timer_eight_ch4_output),
    .timer_eight_trigger_output (timer_eight_trigger_output),
    .conv_injected_trigger      (conv_injected_trigger),
    .conv_regular_trigger       (conv_regular_trigger)
);

// ### tb/afr_config_tb.sv
`timescale 1ns/1ps
module afr_config_tb;
    reg         clk = 0, rst = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, er;
    reg  [5:0]  wb_adr_i = 0;
    reg  [3:0]  wb_sel_i = 0;
    reg  [31:0] wb_dat_i = 0, rd;
    reg         spi_a_select_active = 0, spi_a_select_level = 0;
    reg         spi_b_select_active = 0, spi_b_select_level = 0;
    reg  [15:0] external_interrupt_lines = 0;
    reg         timer_eight_ch4_output = 0, timer_eight_trigger_output = 0;
    wire [31:0] wb_dat_o, pin_filter_ab, pin_filter_cd, digital_filter_ab, digital_filter_cd;
    wire [4:0]  io_filter_config_field;
    wire        wb_ack_o, wb_err_o, spi_a_select_o, spi_a_select_oe, spi_b_select_o;
    wire        spi_b_select_oe, conv_injected_trigger, conv_regular_trigger;
    wire [3:0]  spi_pins = {spi_a_select_o, spi_a_select_oe, spi_b_select_o, spi_b_select_oe};
    wire [1:0]  trig_pair = {conv_injected_trigger, conv_regular_trigger};
    reg  [73:0] rows [0:5];
    integer     n_errors = 0, samples_checked = 0, i;
    afr_config dut_u (
        .clk                        (clk),
        .rst                        (rst),
        .wb_cyc_i                   (wb_cyc_i),
        .wb_stb_i                   (wb_stb_i),
        .wb_we_i                    (wb_we_i),
        .wb_adr_i                   (wb_adr_i),
        .wb_sel_i                   (wb_sel_i),
        .wb_dat_i                   (wb_dat_i),
        .wb_dat_o                   (wb_dat_o),
        .wb_ack_o                   (wb_ack_o),
        .wb_err_o                   (wb_err_o),
        .spi_a_select_active        (spi_a_select_active),
        .spi_a_select_level         (spi_a_select_level),
        .spi_b_select_active        (spi_b_select_active),
        .spi_b_select_level         (spi_b_select_level),
        .spi_a_select_o             (spi_a_select_o),
        .spi_a_select_oe            (spi_a_select_oe),
        .spi_b_select_o             (spi_b_select_o),
        .spi_b_select_oe            (spi_b_select_oe),
        .external_interrupt_lines   (external_interrupt_lines),
        .timer_eight_ch4_output     (timer_eight_ch4_output),
        .timer_eight_trigger_output (timer_eight_trigger_output),
        .conv_injected_trigger      (conv_injected_trigger),
        .conv_regular_trigger       (conv_regular_trigger),
        .pin_filter_ab              (pin_filter_ab),
        .pin_filter_cd              (pin_filter_cd),
        .io_filter_config_field     (io_filter_config_field),
        .digital_filter_ab          (digital_filter_ab),
        .digital_filter_cd          (digital_filter_cd)
    );
    initial forever #4 clk = ~clk;
    initial begin
        #20000;
        n_errors++;
        stop_test;
    end
    task stop_test;
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task chk(input string nm, input [31:0] e, input [31:0] g);
        samples_checked++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    // the watchdog bounds this wait
    task bus(input [5:0] a, input w, input [3:0] s, input [31:0] d);
        @(posedge clk);
        wb_cyc_i <= 1;
        wb_stb_i <= 1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= d;
        @(posedge clk);
        while (wb_ack_o !== 1 && wb_err_o !== 1) @(posedge clk);
        rd = wb_dat_o;
        er = wb_err_o;
        wb_cyc_i <= 0;
        wb_stb_i <= 0;
    endtask
    task src(input [15:0] x, input c, input t);
        external_interrupt_lines <= x;
        timer_eight_ch4_output <= c;
        timer_eight_trigger_output <= t;
        repeat (5) @(posedge clk);
    endtask
    initial begin
        rows[0] = {6'h00, 4'hf, 32'h00000a5c, 32'h00000a5c};
        rows[1] = {6'h18, 4'h1, 32'ha5a5a5a5, 32'h000000a5};
        rows[2] = {6'h1c, 4'hf, 32'hffffffff, 32'hf001e000};
        rows[3] = {6'h20, 4'he, 32'hffffffff, 32'h00000000};
        rows[4] = {6'h24, 4'hf, 32'h5a5a5a5a, 32'h5a5a5a5a};
        rows[5] = {6'h28, 4'hf, 32'hffffffff, 32'hf001e000};
        repeat (2) @(posedge clk);
        rst <= 0;
        for (i = 0; i < 6; i++) begin
            bus(rows[i][73:68], 1, rows[i][67:64], rows[i][63:32]);
            bus(rows[i][73:68], 0, 4'hf, 0);
            chk("readback", rows[i][31:0], rd);
            chk("mapped err", 0, er);
        end
        chk("pin_filter_ab", rows[1][31:0], pin_filter_ab);
        chk("pin_filter_cd", rows[2][31:0], pin_filter_cd);
        chk("digital_filter_ab", rows[4][31:0], digital_filter_ab);
        chk("digital_filter_cd", rows[5][31:0], digital_filter_cd);
        bus(6'h20, 1, 4'h1, 32'hffffffff);
        bus(6'h20, 0, 4'hf, 0);
        chk("filter setting readback", 32'h0000001f, rd);
        chk("io_filter_config_field", 32'h0000001f, io_filter_config_field);
        bus(6'h04, 1, 4'hf, 32'hffffffff);
        chk("unmapped write err", 1, er);
        bus(6'h04, 0, 4'hf, 0);
        chk("unmapped err", 1, er);
        chk("unmapped data", 0, rd);
        spi_a_select_active <= 1;
        spi_b_select_active <= 1;
        spi_b_select_level <= 1;
        bus(6'h00, 1, 4'hf, 32'h00000800);
        src(0, 0, 0);
        chk("spi pins active", 4'h7, spi_pins);
        spi_a_select_active <= 0;
        spi_b_select_active <= 0;
        src(0, 0, 0);
        chk("spi pins idle", 4'he, spi_pins);
        bus(6'h00, 1, 4'hf, 32'h000004a5);
        @(posedge clk);
        chk("spi pins idle", 4'hb, spi_pins);
        src(16'h0020, 1, 1);
        chk("trigger", 1, trig_pair);
        src(16'h0400, 1, 1);
        chk("trigger", 2, trig_pair);
        bus(6'h00, 1, 4'hf, 32'h00000300);
        src(16'h0400, 0, 1);
        chk("trigger", 1, trig_pair);
        src(16'hffff, 1, 1);
        src(0, 0, 0);
        rst <= 1;
        @(posedge clk);
        rst <= 0;
        for (i = 0; i < 6; i++) begin
            bus(rows[i][73:68], 0, 4'hf, 0);
            chk("reset", 0, rd);
        end
        chk("spi pins after reset", 4'ha, spi_pins);
        chk("trigger after reset", 0, trig_pair);
        chk("filters ab after reset", 0, pin_filter_ab | digital_filter_ab);
        chk("filters cd after reset", 0, pin_filter_cd | digital_filter_cd);
        chk("filter setting after reset", 0, io_filter_config_field);
        stop_test;
    end
endmodule
